// >>> logic/modulator_submodule_map.vh
// Register map, field positions and reset values of the modulator submodule.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef MODULATOR_SUBMODULE_MAP_VH
`define MODULATOR_SUBMODULE_MAP_VH

// Register indices; byte address is four times the index
`define MODULATOR_SUBMODULE_IDX_SIC      4'h0
`define MODULATOR_SUBMODULE_IDX_PERIOD   4'h2
`define MODULATOR_SUBMODULE_IDX_WIDTH    4'h4
`define MODULATOR_SUBMODULE_IDX_COUNT    4'h6
`define MODULATOR_SUBMODULE_IDX_CFG      4'h8

// Status and control register fields
`define MODULATOR_SUBMODULE_FLAG_BIT     15
`define MODULATOR_SUBMODULE_IL_HI        14
`define MODULATOR_SUBMODULE_IL_LO        12
`define MODULATOR_SUBMODULE_ARB3_BIT     11
`define MODULATOR_SUBMODULE_PIN_BIT      7
`define MODULATOR_SUBMODULE_LOAD_BIT     5
`define MODULATOR_SUBMODULE_POL_BIT      4
`define MODULATOR_SUBMODULE_EN_BIT       3
`define MODULATOR_SUBMODULE_CLK_HI       2
`define MODULATOR_SUBMODULE_CLK_LO       0

// Configuration register fields
`define MODULATOR_SUBMODULE_DIVIDE_TWO_OR_THREE_SELECT_BIT    8
`define MODULATOR_SUBMODULE_MARB_HI      2
`define MODULATOR_SUBMODULE_MARB_LO      0

// Reset values
`define MODULATOR_SUBMODULE_COUNT_RST    16'h0001
`define MODULATOR_SUBMODULE_DATA_RST     16'h0000
`define MODULATOR_SUBMODULE_IL_RST       3'h0
`define MODULATOR_SUBMODULE_CLK_RST      3'h0

// Prescaler first tap terminal counts (divide by two or three)
`define MODULATOR_SUBMODULE_TAP_DIV2     2'h1
`define MODULATOR_SUBMODULE_TAP_DIV3     2'h2

// Bus responses
`define MODULATOR_SUBMODULE_RESP_OKAY    2'h0
`define MODULATOR_SUBMODULE_RESP_SLVERR  2'h2

`endif

// >>> logic/modulator_submodule_top.v
// One pulse width modulator submodule with its AXI4-Lite register slave.
// Assumes ref_clk is the system clock and rst a synchronous active-high reset;
// the bus master keeps one write and one read outstanding at most.
//
// Contract
// - Period end sets flag; flag is sticky
// - Enabling sets the flag at once
// - Flag cleared by read-one then write-zero
// - Nonzero level raises request when flag set
// - Arbitration number is bit three plus field
// - Pin bit reads output level, ignores writes
// - Load refreshes buffers, counter one, sets flag
// - Load sets output only for nonzero width
// - Load while disabled does nothing
// - Output level from polarity and enable
// - Disabled holds output, prescaler, counter; buffers track latches
// - Enable rise starts pulse, prescaler, counter
// - Enabled refreshes buffers at each period end
// - Clock field picks one of eight rates
// - Period enters buffer at period end or load
// - Width follows the same buffer timing
// - Hardware never alters period or width latches
// - Counter read-only, one at reset and disabled
`timescale 1ns/1ps
`include "modulator_submodule_map.vh"

module modulator_submodule_top
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // AXI4-Lite write address and data
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Modulated pin and interrupt request
  output wire        pwm_pin,
  output wire [2:0]  irq_level,
  output wire [3:0]  irq_arb_num
);

  // Bus slave state
  reg        awready_ff;
  reg        wready_ff;
  reg        aw_hold_ff;
  reg        w_hold_ff;
  reg [3:0]  aw_idx_ff;
  reg [15:0] wdata_ff;
  reg [1:0]  wstrb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;
  reg        arready_ff;
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0]  rresp_ff;

  // Software registers
  reg        flag_ff;
  reg        armed_ff;
  reg [2:0]  il_ff;
  reg        arb3_ff;
  reg        pol_ff;
  reg        en_ff;
  reg        en_q_ff;
  reg [2:0]  clk_sel_ff;
  reg [15:0] period_latch_ff;
  reg [15:0] width_latch_ff;
  reg [2:0]  marb_ff;
  reg        divide_two_or_three_select_ff;

  // Modulator engine
  reg [15:0] period_buffer_ff;
  reg [15:0] width_buffer_ff;
  reg [15:0] count_ff;
  reg        out_ff;
  reg [1:0]  tap_cnt_ff;
  reg [7:0]  pre_ff;
  reg        pin_ff;
  reg [2:0]  irq_level_ff;
  reg [3:0]  irq_arb_ff;

  wire       nxt_aw_hold;
  wire       nxt_w_hold;
  wire       aw_take;
  wire       w_take;
  wire       wr_go;
  wire       ar_take;
  wire       wr_sic;
  wire       wr_map;
  wire [3:0] ar_idx;
  wire       load_req;
  wire       en_rise;
  wire       tap_pulse;
  wire [7:0] rate_mask;
  wire       tick;
  wire       period_end;
  wire       flag_set;
  wire       flag_clr;
  reg [15:0] rd_val;
  reg        rd_ok;

  // Merge the two low byte lanes into a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  strb;
    begin
      lane_merge = {strb[1] ? new_val[15:8] : old_val[15:8],
                    strb[0] ? new_val[7:0] : old_val[7:0]};
    end
  endfunction

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign pwm_pin       = pin_ff;
  assign irq_level     = irq_level_ff;
  assign irq_arb_num   = irq_arb_ff;

  // Address and data are taken in either order; the write lands once both are held
  assign aw_take     = s_axi_awvalid && awready_ff;
  assign w_take      = s_axi_wvalid && wready_ff;
  assign wr_go       = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign nxt_aw_hold = wr_go ? 1'b0 : (aw_take ? 1'b1 : aw_hold_ff);
  assign nxt_w_hold  = wr_go ? 1'b0 : (w_take ? 1'b1 : w_hold_ff);
  assign ar_take     = s_axi_arvalid && arready_ff;
  assign ar_idx      = s_axi_araddr[5:2];

  // Write address decode
  assign wr_sic = wr_go && (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_SIC);
  assign wr_map = (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_SIC) || (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_PERIOD) ||
                  (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_WIDTH) || (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_COUNT) ||
                  (aw_idx_ff == `MODULATOR_SUBMODULE_IDX_CFG);

  // Write channel handshake and response
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_idx_ff  <= 4'h0;
      wdata_ff   <= `MODULATOR_SUBMODULE_DATA_RST;
      wstrb_ff   <= 2'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `MODULATOR_SUBMODULE_RESP_OKAY;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awready_ff <= !nxt_aw_hold;
      wready_ff  <= !nxt_w_hold;
      if (aw_take)
        aw_idx_ff <= s_axi_awaddr[5:2];
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata[15:0];
        wstrb_ff <= s_axi_wstrb[1:0];
      end
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? `MODULATOR_SUBMODULE_RESP_OKAY : `MODULATOR_SUBMODULE_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Read decode; the counter is visible at any time, pin shows the real level
  always @*
  begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    if (ar_idx == `MODULATOR_SUBMODULE_IDX_SIC)
      rd_val = {flag_ff, il_ff, arb3_ff, 3'h0, pin_ff, 2'h0, pol_ff, en_ff,
                clk_sel_ff};
    else if (ar_idx == `MODULATOR_SUBMODULE_IDX_PERIOD)
      rd_val = period_latch_ff;
    else if (ar_idx == `MODULATOR_SUBMODULE_IDX_WIDTH)
      rd_val = width_latch_ff;
    else if (ar_idx == `MODULATOR_SUBMODULE_IDX_COUNT)
      rd_val = count_ff;
    else if (ar_idx == `MODULATOR_SUBMODULE_IDX_CFG)
      rd_val = {7'h00, divide_two_or_three_select_ff, 5'h00, marb_ff};
    else
      rd_ok = 1'b0;
  end

  // Read channel; one read in flight, data registered on the taking edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `MODULATOR_SUBMODULE_RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {16'h0000, rd_val};
      rresp_ff   <= rd_ok ? `MODULATOR_SUBMODULE_RESP_OKAY : `MODULATOR_SUBMODULE_RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
    else if (!rvalid_ff)
      arready_ff <= 1'b1;
  end

  // Control fields; pin and load bits are not stored, so load always reads zero
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      il_ff           <= `MODULATOR_SUBMODULE_IL_RST;
      arb3_ff         <= 1'b0;
      pol_ff          <= 1'b0;
      en_ff           <= 1'b0;
      en_q_ff         <= 1'b0;
      clk_sel_ff      <= `MODULATOR_SUBMODULE_CLK_RST;
      period_latch_ff <= `MODULATOR_SUBMODULE_DATA_RST;
      width_latch_ff  <= `MODULATOR_SUBMODULE_DATA_RST;
      marb_ff         <= 3'h0;
      divide_two_or_three_select_ff        <= 1'b0;
    end
    else
    begin
      en_q_ff <= en_ff;
      if (wr_sic && wstrb_ff[1])
      begin
        il_ff   <= wdata_ff[`MODULATOR_SUBMODULE_IL_HI:`MODULATOR_SUBMODULE_IL_LO];
        arb3_ff <= wdata_ff[`MODULATOR_SUBMODULE_ARB3_BIT];
      end
      if (wr_sic && wstrb_ff[0])
      begin
        pol_ff     <= wdata_ff[`MODULATOR_SUBMODULE_POL_BIT];
        en_ff      <= wdata_ff[`MODULATOR_SUBMODULE_EN_BIT];
        clk_sel_ff <= wdata_ff[`MODULATOR_SUBMODULE_CLK_HI:`MODULATOR_SUBMODULE_CLK_LO];
      end
      // Only software writes touch the latches
      if (wr_go && aw_idx_ff == `MODULATOR_SUBMODULE_IDX_PERIOD)
        period_latch_ff <= lane_merge(period_latch_ff, wdata_ff, wstrb_ff);
      if (wr_go && aw_idx_ff == `MODULATOR_SUBMODULE_IDX_WIDTH)
        width_latch_ff <= lane_merge(width_latch_ff, wdata_ff, wstrb_ff);
      if (wr_go && aw_idx_ff == `MODULATOR_SUBMODULE_IDX_CFG && wstrb_ff[1])
        divide_two_or_three_select_ff <= wdata_ff[`MODULATOR_SUBMODULE_DIVIDE_TWO_OR_THREE_SELECT_BIT];
      if (wr_go && aw_idx_ff == `MODULATOR_SUBMODULE_IDX_CFG && wstrb_ff[0])
        marb_ff <= wdata_ff[`MODULATOR_SUBMODULE_MARB_HI:`MODULATOR_SUBMODULE_MARB_LO];
    end
  end

  // Load acts only while already enabled
  assign load_req = wr_sic && wstrb_ff[0] && wdata_ff[`MODULATOR_SUBMODULE_LOAD_BIT] && en_ff;
  assign en_rise  = en_ff && !en_q_ff;

  // First tap divides by two or three; rate mask picks the prescaler stage
  assign tap_pulse = tap_cnt_ff == (divide_two_or_three_select_ff ? `MODULATOR_SUBMODULE_TAP_DIV3 : `MODULATOR_SUBMODULE_TAP_DIV2);
  assign rate_mask = (clk_sel_ff == 3'h7) ? 8'hFF :
                     (8'h01 << clk_sel_ff) - 8'h01;
  assign tick      = tap_pulse && ((pre_ff & rate_mask) == rate_mask);
  assign period_end = tick && (count_ff == period_buffer_ff);

  // Counter, buffers and output flip-flop
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_ff         <= `MODULATOR_SUBMODULE_COUNT_RST;
      out_ff           <= 1'b0;
      tap_cnt_ff       <= 2'h0;
      pre_ff           <= 8'h00;
      period_buffer_ff <= `MODULATOR_SUBMODULE_DATA_RST;
      width_buffer_ff  <= `MODULATOR_SUBMODULE_DATA_RST;
    end
    else if (!en_ff)
    begin
      // Held idle; buffers track the latches every cycle
      count_ff         <= `MODULATOR_SUBMODULE_COUNT_RST;
      out_ff           <= 1'b0;
      tap_cnt_ff       <= 2'h0;
      pre_ff           <= 8'h00;
      period_buffer_ff <= period_latch_ff;
      width_buffer_ff  <= width_latch_ff;
    end
    else if (en_rise || load_req)
    begin
      // Restart the sequence; prescaler released from zero
      count_ff         <= `MODULATOR_SUBMODULE_COUNT_RST;
      tap_cnt_ff       <= 2'h0;
      pre_ff           <= 8'h00;
      period_buffer_ff <= period_latch_ff;
      width_buffer_ff  <= width_latch_ff;
      if (en_rise)
        out_ff <= 1'b1;
      else
        out_ff <= width_latch_ff != 16'h0000;
    end
    else
    begin
      tap_cnt_ff <= tap_pulse ? 2'h0 : tap_cnt_ff + 2'h1;
      if (tap_pulse)
        pre_ff <= pre_ff + 8'h01;
      if (period_end)
      begin
        // New period from freshly buffered values
        count_ff         <= `MODULATOR_SUBMODULE_COUNT_RST;
        period_buffer_ff <= period_latch_ff;
        width_buffer_ff  <= width_latch_ff;
        out_ff           <= width_latch_ff != 16'h0000;
      end
      else if (tick)
      begin
        count_ff <= count_ff + 16'h0001;
        // Zero width must not leave the first pulse high
        if (count_ff == width_buffer_ff || width_buffer_ff == 16'h0000)
          out_ff <= 1'b0;
      end
    end
  end

  // Period-complete flag; a set in the same cycle as a clear wins
  assign flag_set = en_rise || load_req || period_end;
  assign flag_clr = wr_sic && wstrb_ff[1] && !wdata_ff[`MODULATOR_SUBMODULE_FLAG_BIT] && armed_ff;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      flag_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      if (!en_ff)
        flag_ff <= 1'b0;
      else if (flag_set)
        flag_ff <= 1'b1;
      else if (flag_clr)
        flag_ff <= 1'b0;
      // Arm only after software has seen the flag as one
      if (ar_take && ar_idx == `MODULATOR_SUBMODULE_IDX_SIC && flag_ff)
        armed_ff <= 1'b1;
      else if (wr_sic || !flag_ff)
        armed_ff <= 1'b0;
    end
  end

  // Registered pin, request level and arbitration number
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_ff       <= 1'b0;
      irq_level_ff <= 3'h0;
      irq_arb_ff   <= 4'h0;
    end
    else
    begin
      pin_ff       <= en_ff ? (out_ff ^ pol_ff) : pol_ff;
      irq_level_ff <= flag_ff ? il_ff : 3'h0;
      irq_arb_ff   <= {arb3_ff, marb_ff};
    end
  end

endmodule // modulator_submodule_top

// >>> sim/modulator_submodule_top_properties.sv
// Checker for the modulator submodule: bus handshakes, pin, level and arbitration number.
// Assumes one clock with a synchronous active-high reset; bound to modulator_submodule_top below.
`timescale 1ns/1ps
`include "modulator_submodule_map.vh"

module modulator_submodule_top_properties
(
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Write channels
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [5:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pin and request
  input wire        pwm_pin,
  input wire [2:0]  irq_level,
  input wire [3:0]  irq_arb_num
);
  localparam logic [5:0] A_SIC = {`MODULATOR_SUBMODULE_IDX_SIC, 2'b00};
  localparam logic [5:0] A_CNT = {`MODULATOR_SUBMODULE_IDX_COUNT, 2'b00};
  localparam logic [5:0] A_CFG = {`MODULATOR_SUBMODULE_IDX_CFG, 2'b00};
  logic [5:0]  wa_ff;
  logic [5:0]  ra_ff;
  logic [15:0] wd_ff;
  logic [15:0] sic_ff;
  logic [2:0]  cfg_ff;
  logic [2:0]  quiet_ff;
  logic        idle;

  // Settled only a few cycles after a write reply, so pipeline lag never fires
  assign idle = quiet_ff > 3'h3;

  // Shadow of what software wrote; full strobes assumed
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wa_ff    <= 6'h00;
      ra_ff    <= 6'h00;
      wd_ff    <= 16'h0000;
      sic_ff   <= 16'h0000;
      cfg_ff   <= 3'h0;
      quiet_ff <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[15:0];
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      if (s_axi_bvalid && s_axi_bready && wa_ff == A_SIC) sic_ff <= wd_ff;
      if (s_axi_bvalid && s_axi_bready && wa_ff == A_CFG) cfg_ff <= wd_ff[2:0];
      quiet_ff <= s_axi_bvalid ? 3'h0 : (quiet_ff == 3'h7 ? 3'h7 : quiet_ff + 3'h1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write reply dropped early");
  a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_unmapped: assert property (s_axi_rvalid && ra_ff[2] |-> s_axi_rresp == `MODULATOR_SUBMODULE_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_load_reads_zero: assert property (s_axi_rvalid && ra_ff == A_SIC |-> !s_axi_rdata[5])
    else $error("load bit read as one");
  a_count_held: assert property (
    s_axi_rvalid && ra_ff == A_CNT && !sic_ff[3] && idle |-> s_axi_rdata[15:0] == 16'h0001)
    else $error("count not one while disabled");
  a_pin_bit_idle: assert property (
    s_axi_rvalid && ra_ff == A_SIC && !sic_ff[3] && idle |-> s_axi_rdata[7] == sic_ff[4])
    else $error("pin bit differs from idle level");
  a_pin_idle_pol: assert property (!sic_ff[3] && idle |-> pwm_pin == sic_ff[4])
    else $error("idle pin not at polarity");
  a_irq_idle: assert property (!sic_ff[3] && idle |-> irq_level == 3'h0)
    else $error("request while disabled");
  a_irq_level_sel: assert property (idle |-> irq_level == 3'h0 || irq_level == sic_ff[14:12])
    else $error("request on wrong level");
  a_enable_flag: assert property (
    $rose(sic_ff[3]) && sic_ff[14:12] != 3'h0 |-> ##[0:4] irq_level == sic_ff[14:12])
    else $error("no request after enable");
  a_arb_number: assert property (idle |-> irq_arb_num == {sic_ff[11], cfg_ff})
    else $error("arbitration number wrong");
endmodule // modulator_submodule_top_properties

bind modulator_submodule_top modulator_submodule_top_properties u_props (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pwm_pin, .irq_level, .irq_arb_num);

// >>> sim/modulator_submodule_top_tb.sv
// Self-checking bench for the modulator submodule over its register bus.
// Assumes the design answers every handshake; a watchdog ends any hang.
`timescale 1ns/1ps
`include "modulator_submodule_map.vh"

module modulator_submodule_top_tb;
  localparam logic [5:0] A_SIC = {`MODULATOR_SUBMODULE_IDX_SIC, 2'b00};
  localparam logic [5:0] A_PER = {`MODULATOR_SUBMODULE_IDX_PERIOD, 2'b00};
  localparam logic [5:0] A_WID = {`MODULATOR_SUBMODULE_IDX_WIDTH, 2'b00};
  localparam logic [5:0] A_CNT = {`MODULATOR_SUBMODULE_IDX_COUNT, 2'b00};
  localparam logic [5:0] A_CFG = {`MODULATOR_SUBMODULE_IDX_CFG, 2'b00};
  localparam logic [5:0] A_BAD = 6'h04;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  s_axi_awaddr = 6'h00;
  logic [5:0]  s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         pwm_pin;
  wire  [2:0]  irq_level;
  wire  [3:0]  irq_arb_num;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          hi, lo, n;
  logic [31:0] rd;
  logic [1:0]  rs;

  modulator_submodule_top dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pwm_pin, .irq_level, .irq_arb_num);

  // System clock, 100 MHz
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // Bus write; each channel dropped at the edge that takes it; only the watchdog ends a wait
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  // Bus read; data taken at the edge where rvalid is seen
  task automatic rdr(input logic [5:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // High and low cycles of one full pulse, from a rising edge; a stuck pin hangs to the watchdog
  task automatic measure;
    hi = 0;
    lo = 0;
    while (pwm_pin !== 1'b0)
      @(posedge ref_clk);
    while (pwm_pin !== 1'b1)
      @(posedge ref_clk);
    while (pwm_pin === 1'b1)
    begin
      @(posedge ref_clk);
      hi++;
    end
    while (pwm_pin === 1'b0)
    begin
      @(posedge ref_clk);
      lo++;
    end
  endtask

  task automatic t_reset;
    logic [5:0]  adr [6] = '{A_SIC, A_PER, A_WID, A_CNT, A_CFG, A_BAD};
    logic [15:0] val [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    wr(A_CNT, 16'h1234);
    for (int i = 0; i < 6; i++)
    begin
      rdr(adr[i]);
      chk("reset_value", {16'h0000, val[i]}, rd);
      chk("read_resp", 32'(i == 5 ? `MODULATOR_SUBMODULE_RESP_SLVERR : `MODULATOR_SUBMODULE_RESP_OKAY), 32'(rs));
    end
    wr(A_BAD, 16'h0055);
    chk("write_resp", 32'(`MODULATOR_SUBMODULE_RESP_SLVERR), 32'(rs));
    // Upper byte lane only; the low byte must keep its old value
    s_axi_wstrb <= 4'h2;
    wr(A_PER, 16'h12ab);
    s_axi_wstrb <= 4'hf;
    rdr(A_PER);
    chk("lane_write", 32'h0000_1200, rd);
  endtask

  // Idle with polarity one, load requested while disabled
  task automatic t_disabled;
    wr(A_PER, 16'h00c8);
    wr(A_WID, 16'h0064);
    wr(A_SIC, 16'h0030);
    cyc(4);
    chk("pin_idle", 32'h0000_0001, 32'(pwm_pin));
    rdr(A_SIC);
    chk("status_idle", 32'h0000_0090, rd);
  endtask

  // Enable, waveform, then a width change at the period boundary
  task automatic t_enable;
    wr(A_CFG, 16'h0005);
    wr(A_SIC, 16'h3808);
    cyc(3);
    chk("irq_enable", 32'h0000_0003, 32'(irq_level));
    chk("arb_num", 32'h0000_000d, 32'(irq_arb_num));
    chk("first_pulse", 32'h0000_0001, 32'(pwm_pin));
    measure;
    measure;
    chk("high_200", 32'd200, 32'(hi));
    chk("low_200", 32'd200, 32'(lo));
    wr(A_WID, 16'h0032);
    measure;
    chk("high_100", 32'd100, 32'(hi));
    chk("low_300", 32'd300, 32'(lo));
    rdr(A_PER);
    chk("period_kept", 32'h0000_00c8, rd);
  endtask

  // Clear needs read-one first; next period end sets the flag again
  task automatic t_flag;
    measure;
    wr(A_SIC, 16'h3808);
    cyc(3);
    chk("flag_kept", 32'h0000_0003, 32'(irq_level));
    rdr(A_SIC);
    chk("flag_read", 32'h0000_0001, 32'(rd[15]));
    wr(A_SIC, 16'h3808);
    cyc(3);
    chk("flag_clear", 32'h0000_0000, 32'(irq_level));
    cyc(400);
    chk("flag_again", 32'h0000_0003, 32'(irq_level));
  endtask

  // Load with zero and nonzero width, then a clean disable
  task automatic t_load;
    rdr(A_SIC);
    wr(A_SIC, 16'h3808);
    wr(A_WID, 16'h0000);
    wr(A_SIC, 16'h3828);
    rdr(A_CNT);
    chk("count_restart", 32'h0000_0001, 32'(rd < 32'h0000_0008));
    chk("flag_on_load", 32'h0000_0003, 32'(irq_level));
    n = 0;
    // Unknown counts as high so it cannot pass
    repeat (100)
    begin
      @(posedge ref_clk);
      if (pwm_pin !== 1'b0)
        n++;
    end
    chk("zero_duty", 32'h0000_0000, 32'(n));
    wr(A_WID, 16'h0064);
    wr(A_SIC, 16'h3828);
    cyc(2);
    chk("load_sets_pin", 32'h0000_0001, 32'(pwm_pin));
    wr(A_WID, 16'h0000);
    wr(A_SIC, 16'h3828);
    wr(A_SIC, 16'h3000);
    cyc(4);
    chk("pin_off", 32'h0000_0000, 32'(pwm_pin));
    rdr(A_CNT);
    chk("count_held", 32'h0000_0001, rd);
  endtask

  // Every clock rate, plus the divide-by-three tap
  task automatic t_rates;
    int dv [9] = '{2, 4, 8, 16, 32, 64, 128, 512, 3};
    wr(A_PER, 16'h0002);
    wr(A_WID, 16'h0001);
    for (int k = 0; k < 9; k++)
    begin
      wr(A_CFG, k == 8 ? 16'h0100 : 16'h0000);
      wr(A_SIC, 16'h0008 | 16'(k % 8));
      measure;
      measure;
      chk("tick_high", 32'(dv[k]), 32'(hi));
      chk("tick_low", 32'(dv[k]), 32'(lo));
    end
    // Inverted polarity while running: one tick high out becomes low pin
    wr(A_PER, 16'h0003);
    wr(A_SIC, 16'h0018);
    measure;
    measure;
    chk("inv_high", 32'd6, 32'(hi));
    chk("inv_low", 32'd3, 32'(lo));
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
    t_reset;
    t_disabled;
    t_enable;
    t_flag;
    t_load;
    t_rates;
    tally_and_finish;
  end

  // Watchdog, well beyond the expected run
  initial
  begin
    #400_000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // modulator_submodule_top_tb
